// >>> hw/nvsc_params.svh
`ifndef NVSC_PARAMS_SVH
`define NVSC_PARAMS_SVH

// Prefix addresses of every special sequence, low 14 bits.
`define NVSC_SEQ_A1          14'h0E38
`define NVSC_SEQ_A2          14'h31C7
`define NVSC_SEQ_A3          14'h03E0
`define NVSC_SEQ_A4          14'h3C1F
`define NVSC_SEQ_A5          14'h303F
// Sixth addresses that select the operation.
`define NVSC_SEQ_AUTO_OFF    14'h0B45
`define NVSC_SEQ_AUTO_ON     14'h0B46
`define NVSC_SEQ_RESTORE     14'h0C63
`define NVSC_SEQ_SAVE        14'h0FC0
// Bus timing in ns and derived cycles at 125 MHz.
`define NVSC_CLK_PERIOD_NS   8
`define NVSC_T_ACCESS_NS     35
`define NVSC_ACCESS_CYC      ((`NVSC_T_ACCESS_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_T_GAP_NS        8
`define NVSC_GAP_CYC         ((`NVSC_T_GAP_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
// Post-busy guard time in ns, before the host resumes access.
`define NVSC_T_GUARD_NS      20000
`define NVSC_GUARD_CYC       ((`NVSC_T_GUARD_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)

`endif

// >>> hw/nvsc_pkg.sv
package nvsc_pkg;

   // Operations that a special sequence can request.
   typedef enum logic [1:0] {
      NVSC_OP_AUTO_OFF,
      NVSC_OP_AUTO_ON,
      NVSC_OP_SAVE,
      NVSC_OP_RESTORE
   } nvsc_op_t;

   // Strobes and address toward the memory; strobes are active low.
   typedef struct packed {
      logic        chip_sel_n;
      logic        out_en_n;
      logic        write_n;
      logic [14:0] address_lines;
   } nvsc_mem_bus_t;

endpackage : nvsc_pkg

// >>> hw/nvsc_read_cycle.sv
`timescale 1ns/1ns
`include "nvsc_params.svh"

// Runs one framed read at the memory: strobe low for the access time, then a gap.
module nvsc_read_cycle
   import nvsc_pkg::*;
#(
   parameter int ACCESS_CYC = `NVSC_ACCESS_CYC,
   parameter int GAP_CYC    = `NVSC_GAP_CYC
) (
   // Clock and reset.
   input  wire logic          clk,
   input  wire logic          reset_n,
   // Request.
   input  wire logic          start,
   input  wire logic          use_oe,
   input  wire logic [14:0]   addr,
   // Result.
   output logic               done,
   output nvsc_mem_bus_t      mem_bus
);

   localparam int CW = 16;

   logic [CW-1:0] cnt_q;
   logic          act_q;
   logic          strobe_q;
   logic          use_oe_q;
   logic [14:0]   addr_q;
   logic          last;

   assign last = act_q && (cnt_q == CW'(ACCESS_CYC + GAP_CYC - 1));

   // Counts the strobe-low phase followed by the recovery gap.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q    <= '0;
         act_q    <= 1'b0;
         strobe_q <= 1'b0;
         use_oe_q <= 1'b0;
         addr_q   <= 15'h0000;
      end else if (start && !act_q) begin
         cnt_q    <= '0;
         act_q    <= 1'b1;
         strobe_q <= 1'b1;
         use_oe_q <= use_oe;
         addr_q   <= addr;
      end else if (act_q) begin
         cnt_q    <= cnt_q + CW'(1);
         strobe_q <= (cnt_q < CW'(ACCESS_CYC - 1));
         act_q    <= !last;
      end
   end

   // Output enable always frames the read; with use_oe_q set chip select stays low, otherwise chip select pulses with it.
   assign done                  = last;
   assign mem_bus.write_n       = 1'b1;
   assign mem_bus.chip_sel_n    = use_oe_q ? 1'b0 : !strobe_q;
   assign mem_bus.out_en_n      = use_oe_q ? !strobe_q : !strobe_q;
   assign mem_bus.address_lines = addr_q;

endmodule : nvsc_read_cycle

// >>> hw/nvsc_host_seq.sv
`timescale 1ns/1ns
`include "nvsc_params.svh"

module nvsc_host_seq
   import nvsc_pkg::*;
#(
   parameter int GUARD_CYC = `NVSC_GUARD_CYC
) (
   // Clock and reset.
   input  wire logic          clk,
   input  wire logic          reset_n,
   // Command port.
   input  wire logic          cmd_valid,
   input  wire nvsc_op_t      cmd_op,
   input  wire logic          cmd_use_oe,
   input  wire logic          cmd_addr_top,
   output logic               cmd_ready,
   output logic               cmd_done,
   // Memory pins.
   output nvsc_mem_bus_t      mem_bus,
   input  wire logic          save_busy_handshake_in,
   output logic               save_busy_handshake_out,
   output logic               save_busy_handshake_oe,
   // Supply state and status.
   input  wire logic          supply_low,
   output logic               auto_save_on,
   output logic               save_pending
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_WAIT_BUSY,
      ST_GUARD,
      ST_DONE
   } nvsc_state_t;

   // Guard counter width; wide enough for the default guard time.
   localparam int GW = 24;

   // Sequencer registers and decode wires.
   nvsc_state_t   state_q, state_d;
   logic [2:0]    idx_q;
   nvsc_op_t      op_q;
   logic          use_oe_q;
   logic          top_q;
   logic [GW-1:0] guard_q;
   logic          auto_q;
   logic          pend_q;
   logic          rd_start;
   logic          rd_done;
   logic [13:0]   seq_addr;
   logic [13:0]   last_addr;
   logic          last_step;
   logic          needs_busy;
   logic          cmd_take;
   logic          op_is_auto;
   logic          save_refused;
   logic          busy_low;
   logic          guard_full;
   logic          seq_end;

   // The final address picks the operation.
   assign last_addr = (op_q == NVSC_OP_AUTO_OFF) ? `NVSC_SEQ_AUTO_OFF :
                      (op_q == NVSC_OP_AUTO_ON)  ? `NVSC_SEQ_AUTO_ON  :
                      (op_q == NVSC_OP_RESTORE)  ? `NVSC_SEQ_RESTORE  :
                                                   `NVSC_SEQ_SAVE;
   // Prefix addresses in their fixed order; the sixth slot carries the operation.
   assign seq_addr = (idx_q == 3'd0) ? `NVSC_SEQ_A1 :
                     (idx_q == 3'd1) ? `NVSC_SEQ_A2 :
                     (idx_q == 3'd2) ? `NVSC_SEQ_A3 :
                     (idx_q == 3'd3) ? `NVSC_SEQ_A4 :
                     (idx_q == 3'd4) ? `NVSC_SEQ_A5 : last_addr;

   // End of the sequence, and the operations that make the memory busy.
   assign last_step  = (idx_q == 3'd5);
   assign seq_end    = rd_done && last_step;
   assign needs_busy = (op_q == NVSC_OP_SAVE) || (op_q == NVSC_OP_RESTORE);
   assign op_is_auto = (op_q == NVSC_OP_AUTO_OFF) || (op_q == NVSC_OP_AUTO_ON);

   // Busy line level and guard completion; the memory holds the line low during a save.
   assign busy_low   = !save_busy_handshake_in;
   assign guard_full = (guard_q == GW'(GUARD_CYC));

   // Saves are refused while the supply is low; the memory would block them anyway.
   // A command is taken only from idle with the busy line released.
   assign save_refused = supply_low && (cmd_op == NVSC_OP_SAVE);
   assign cmd_ready    = (state_q == ST_IDLE) && !busy_low && !save_refused;
   assign cmd_take     = cmd_valid && cmd_ready;
   assign rd_start     = (state_q == ST_READ);
   assign cmd_done     = (state_q == ST_DONE);

   // The host never pulls the busy line; it only watches it.
   // The status outputs come straight from their registers.
   assign save_busy_handshake_out = 1'b0;
   assign save_busy_handshake_oe  = 1'b0;
   assign auto_save_on            = auto_q;
   assign save_pending            = pend_q;

   // Six reads issued back to back, nothing else in between. Each read is one full
   // strobe pulse and a recovery gap, so no other access can slip into the sequence
   // and make the memory abort it.
   nvsc_read_cycle u_rd (
      .clk     (clk),
      .reset_n (reset_n),
      .start   (rd_start),
      .use_oe  (use_oe_q),
      .addr    ({top_q, seq_addr}),
      .done    (rd_done),
      .mem_bus (mem_bus)
   );

   // Sequencer next state. Save and restore sequences wait in the guard state until
   // the busy line has stood high for the guard time, so that the memory is ready
   // again before the next command may start a read.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (cmd_take) state_d = ST_READ;
         end
         ST_READ: begin
            if (seq_end) state_d = needs_busy ? ST_WAIT_BUSY : ST_DONE;
         end
         ST_WAIT_BUSY: begin
            // The memory pulls the busy line low while the sixth read is still framed.
            state_d = ST_GUARD;
         end
         ST_GUARD: begin
            if (guard_full) state_d = ST_DONE;
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // State register and command capture; the command fields are held for the whole
   // sequence, so a change at the command port cannot alter a sequence midway.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q  <= ST_IDLE;
         op_q     <= NVSC_OP_SAVE;
         use_oe_q <= 1'b0;
         top_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         if (cmd_take) begin
            op_q     <= cmd_op;
            use_oe_q <= cmd_use_oe;
            top_q    <= cmd_addr_top;
         end
      end
   end

   // Step index through the six addresses; it returns to the first prefix address
   // whenever the sequencer leaves the read state.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         idx_q <= 3'd0;
      end else if (state_q != ST_READ) begin
         idx_q <= 3'd0;
      end else if (rd_done) begin
         idx_q <= idx_q + 3'd1;
      end
   end

   // Guard counter restarts while the busy line is low, so the guard time is
   // measured from the moment the memory releases the line.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         guard_q <= '0;
      end else if (state_q != ST_GUARD || busy_low) begin
         guard_q <= '0;
      end else if (!guard_full) begin
         guard_q <= guard_q + GW'(1);
      end
   end

   // Shadow of the automatic-save setting; it follows the last completed auto-off or auto-on command,
   // since the host cannot read the setting back from the memory.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         auto_q <= 1'b1;
      end else if (cmd_done && op_is_auto) begin
         auto_q <= (op_q == NVSC_OP_AUTO_ON);
      end
   end

   // A setting change leaves a manual save pending; without one the new setting is
   // lost at the next power-down. A completed save sequence clears it.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_q <= 1'b0;
      end else if (cmd_done && op_is_auto) begin
         pend_q <= 1'b1;
      end else if (cmd_done && (op_q == NVSC_OP_SAVE)) begin
         pend_q <= 1'b0;
      end
   end

endmodule : nvsc_host_seq

// >>> verif/nvsc_host_seq_properties.sv
`timescale 1ns/1ns
`include "nvsc_params.svh"
module nvsc_host_seq_properties
   import nvsc_pkg::*;
#(
   parameter int GUARD_CYC = 4
) (
   // Clock and reset.
   input wire logic          clk,
   input wire logic          reset_n,
   // Command port.
   input wire logic          cmd_valid,
   input wire nvsc_op_t      cmd_op,
   input wire logic          cmd_ready,
   input wire logic          cmd_done,
   // Memory side and status.
   input wire nvsc_mem_bus_t mem_bus,
   input wire logic          save_busy_handshake_in,
   input wire logic          supply_low,
   input wire logic          auto_save_on,
   input wire logic          save_pending
);
   // One clock domain, so clocking and reset are shared.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire take = cmd_valid && cmd_ready;
   wire oe_n = mem_bus.out_en_n;
   // Cycles that the busy line has stood high, saturating; full after reset.
   logic [7:0] hi_cnt_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) hi_cnt_q <= 8'hFF;
      else if (!save_busy_handshake_in) hi_cnt_q <= 8'h00;
      else if (hi_cnt_q != 8'hFF) hi_cnt_q <= hi_cnt_q + 8'h01;
   end
   // Checks on the strobes, the command handshake and the status outputs.
   property p_wr_high; mem_bus.write_n; endproperty
   a_wr_high: assert property (p_wr_high) else $error("write strobe low");
   property p_busy; take |-> save_busy_handshake_in && hi_cnt_q > GUARD_CYC; endproperty
   a_busy: assert property (p_busy) else $error("taken inside guard");
   property p_low; supply_low && cmd_op == NVSC_OP_SAVE |-> !cmd_ready; endproperty
   a_low: assert property (p_low) else $error("save taken in low supply");
   property p_first; take |-> ##[1:3] !oe_n && mem_bus.address_lines[13:0] == `NVSC_SEQ_A1;
   endproperty
   a_first: assert property (p_first) else $error("bad first address");
   property p_len; take && cmd_op[1] == 1'b0 |-> ##43 cmd_done; endproperty
   a_len: assert property (p_len) else $error("auto op length");
   property p_pulse; $fell(oe_n) |-> !oe_n [*5] ##1 oe_n; endproperty
   a_pulse: assert property (p_pulse) else $error("strobe width");
   property p_hold; !oe_n && !$past(oe_n) |-> $stable(mem_bus.address_lines); endproperty
   a_hold: assert property (p_hold) else $error("address moved");
   property p_pend; $changed(auto_save_on) |-> ##[0:1] save_pending; endproperty
   a_pend: assert property (p_pend) else $error("no save pending");
endmodule : nvsc_host_seq_properties
bind nvsc_host_seq nvsc_host_seq_properties #(.GUARD_CYC(GUARD_CYC)) nvsc_host_seq_properties_i (
   .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
   .cmd_ready(cmd_ready), .cmd_done(cmd_done), .mem_bus(mem_bus),
   .save_busy_handshake_in(save_busy_handshake_in), .supply_low(supply_low),
   .auto_save_on(auto_save_on), .save_pending(save_pending));

// >>> verif/nvsc_dev_model.sv
`timescale 1ns/1ns
`include "nvsc_params.svh"
module nvsc_dev_model
   import nvsc_pkg::*;
#(
   parameter int BUSY_CYC = 20,
   parameter int GUARD_CYC = 4
) (
   // Clock and reset.
   input wire logic          clk,
   input wire logic          reset_n,
   // Pins from the host.
   input wire nvsc_mem_bus_t mem_bus,
   input wire logic          supply_low,
   // Busy line and observed state.
   output logic              busy_n,
   output logic              auto_en,
   output int                saves,
   output int                restores,
   output logic              early
);
   localparam logic [13:0] PRE [5] = '{`NVSC_SEQ_A1, `NVSC_SEQ_A2, `NVSC_SEQ_A3,
                                      `NVSC_SEQ_A4, `NVSC_SEQ_A5};
   logic       rd_q;
   logic [2:0] idx_q;
   int         cnt_q;
   int         guard_q;
   // A read starts when both strobes are low; top address line ignored.
   wire        rd = !mem_bus.chip_sel_n && !mem_bus.out_en_n;
   wire [13:0] a  = mem_bus.address_lines[13:0];
   assign busy_n = (cnt_q == 0);
   // Sequence matcher; reads are ignored while a save or restore runs.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_q <= 1'b0;
         idx_q <= 3'h0;
         cnt_q <= 0;
         guard_q <= 0;
         early <= 1'b0;
         auto_en <= 1'b1;
         saves <= 0;
         restores <= 0;
      end else begin
         rd_q <= rd;
         if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
            if (cnt_q == 1) guard_q <= GUARD_CYC;
         end else if (guard_q != 0) begin
            // Access stays inhibited for the guard time after the busy line rises.
            guard_q <= guard_q - 1;
            if (rd && !rd_q) early <= 1'b1;
         end else if (rd && !rd_q) begin
            idx_q <= 3'h0;
            if (idx_q < 3'h5) begin
               if (a == PRE[idx_q]) idx_q <= idx_q + 3'h1;
               else if (a == PRE[0]) idx_q <= 3'h1;
            end else if (a == `NVSC_SEQ_AUTO_OFF) auto_en <= 1'b0;
            else if (a == `NVSC_SEQ_AUTO_ON) auto_en <= 1'b1;
            else if (a == `NVSC_SEQ_SAVE && !supply_low) begin
               cnt_q <= BUSY_CYC;
               saves <= saves + 1;
            end else if (a == `NVSC_SEQ_RESTORE) begin
               cnt_q <= BUSY_CYC;
               restores <= restores + 1;
            end
         end
         if (!mem_bus.write_n) idx_q <= 3'h0;
      end
   end
endmodule : nvsc_dev_model

// >>> verif/testbench.sv
`timescale 1ns/1ns
module testbench;
   import nvsc_pkg::*;
   logic clk = 0, reset_n = 0, cmd_valid = 0, cmd_use_oe = 0, cmd_addr_top = 0, supply_low = 0;
   nvsc_op_t cmd_op = NVSC_OP_AUTO_OFF;
   logic cmd_ready, cmd_done, hs_out, hs_oe, auto_save_on, save_pending, dev_busy_n, dev_auto;
   logic dev_early;
   nvsc_mem_bus_t mem_bus;
   int saves, restores, errors = 0, num_checks = 0;
   // Busy line is open drain with a pull-up.
   wire busy_line = dev_busy_n & ~(hs_oe & ~hs_out);
   always #4 clk = ~clk;
   nvsc_host_seq #(.GUARD_CYC(4)) nvsc_host_seq_i (.clk(clk), .reset_n(reset_n),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_use_oe(cmd_use_oe),
      .cmd_addr_top(cmd_addr_top), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
      .mem_bus(mem_bus), .save_busy_handshake_in(busy_line), .save_busy_handshake_out(hs_out),
      .save_busy_handshake_oe(hs_oe), .supply_low(supply_low), .auto_save_on(auto_save_on),
      .save_pending(save_pending));
   nvsc_dev_model #(.GUARD_CYC(4)) nvsc_dev_model_i (.clk(clk), .reset_n(reset_n),
      .mem_bus(mem_bus), .supply_low(supply_low), .busy_n(dev_busy_n), .auto_en(dev_auto),
      .saves(saves), .restores(restores), .early(dev_early));
   // Compares one value and reports a mismatch.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Issues one command at a falling edge and waits for its completion pulse.
   task automatic do_cmd(input nvsc_op_t op, input logic oe, input logic top);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      {cmd_valid, cmd_op, cmd_use_oe, cmd_addr_top} = {1'b1, op, oe, top};
      @(negedge clk);
      cmd_valid = 0;
      n = 0;
      while (cmd_done !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk(cmd_done, 1);
      @(negedge clk); // Status registers update at the end of the done pulse.
   endtask : do_cmd
   // Scenarios, each judging its own outcome.
   task automatic t_reset;
      chk(auto_save_on, 1);
      chk(dev_auto, 1);
      chk(save_pending, 0);
      chk({30'h0, hs_oe, hs_out}, 32'h0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_auto_off;
      do_cmd(NVSC_OP_AUTO_OFF, 1, 1);
      chk(dev_auto, 0);
      chk(auto_save_on, 0);
      chk(save_pending, 1);
      $display("t_auto_off done");
   endtask : t_auto_off
   task automatic t_auto_on;
      do_cmd(NVSC_OP_AUTO_ON, 0, 0);
      chk(dev_auto, 1);
      $display("t_auto_on done");
   endtask : t_auto_on
   task automatic t_low;
      {supply_low, cmd_op, cmd_valid} = {1'b1, NVSC_OP_SAVE, 1'b1};
      @(negedge clk);
      chk(cmd_ready, 0);
      repeat (3) @(negedge clk);
      chk(saves, 0);
      {supply_low, cmd_valid} = 2'b00;
      $display("t_low done");
   endtask : t_low
   task automatic t_save;
      do_cmd(NVSC_OP_SAVE, 1, 0);
      chk(saves, 1);
      chk(save_pending, 0);
      chk(busy_line, 1);
      $display("t_save done");
   endtask : t_save
   task automatic t_restore;
      do_cmd(NVSC_OP_RESTORE, 0, 1);
      chk(restores, 1);
      chk(saves, 1);
      chk(dev_early, 0);
      $display("t_restore done");
   endtask : t_restore
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   // Main sequence after a four-cycle reset.
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      reset_n = 1;
      t_reset;
      t_auto_off;
      t_auto_on;
      t_low;
      t_save;
      t_restore;
      print_verdict;
   end
   // Watchdog well beyond the expected run of a few hundred cycles.
   initial begin
      #40000;
      errors++;
      print_verdict;
   end
endmodule : testbench
